// ==== verilog/tsr_pkg.sv ====
// tristate register path: shared constants, select codes and reset values
// assumes a single high-speed core clock and a synchronous active-high reset
`default_nettype none

package tsr_pkg;

    // ---------------------------------------------------------------
    // widths and sizes
    // ---------------------------------------------------------------
    localparam int TSR_WORD_W = 4;
    localparam int TSR_FIFO_DEPTH = 4;
    localparam int TSR_CELLS = 4;
    localparam int TSR_SHIFT_REGS = 3;

    // ---------------------------------------------------------------
    // output source select
    // ---------------------------------------------------------------
    localparam logic [1:0] TSR_SRC_BYPASS = 2'h0;
    localparam logic [1:0] TSR_SRC_SDR = 2'h1;
    localparam logic [1:0] TSR_SRC_DDR = 2'h2;
    localparam logic [1:0] TSR_SRC_OPEN_DRAIN = 2'h3;

    // ---------------------------------------------------------------
    // gearing select and cells used per ratio
    // ---------------------------------------------------------------
    localparam logic [1:0] TSR_GEAR_X1 = 2'h0;
    localparam logic [1:0] TSR_GEAR_X2 = 2'h1;
    localparam logic [1:0] TSR_GEAR_X4 = 2'h2;
    localparam logic [1:0] TSR_CNT_X1 = 2'h0;
    localparam logic [1:0] TSR_CNT_X2 = 2'h1;
    localparam logic [1:0] TSR_CNT_X4 = 2'h3;
    localparam logic [3:0] TSR_USED_X1 = 4'h1;
    localparam logic [3:0] TSR_USED_X2 = 4'h3;
    localparam logic [3:0] TSR_USED_X4 = 4'hF;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic TSR_RST_TRISTATE = 1'h1;
    localparam logic TSR_RST_TERM = 1'h0;
    localparam logic TSR_RST_BIT = 1'h0;

endpackage : tsr_pkg

`default_nettype wire

// ==== verilog/tsr_fifo.sv ====
// small flip-flop fifo with valid and ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none

module tsr_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic full;
        logic empty;
        logic in_ready;
    } tsr_fifo_state_type;

    tsr_fifo_state_type state_reg;
    tsr_fifo_state_type state_next;
    logic push;
    logic pop;

    always_comb begin
        push = i_in_valid && !state_reg.full;
        pop = i_out_ready && !state_reg.empty;
        state_next = state_reg;
        if (push) begin
            state_next.mem[state_reg.wr_ptr] = i_in_data;
            state_next.wr_ptr = (state_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_next.rd_ptr = (state_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : state_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            state_next.count = state_reg.count + 1'b1;
        end else if (pop && !push) begin
            state_next.count = state_reg.count - 1'b1;
        end
        state_next.full = (state_next.count == (AW+1)'(DEPTH));
        state_next.empty = (state_next.count == '0);
        // ready reflects room at the very edge that takes the word
        state_next.in_ready = !state_next.full;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_reg <= '0;
            state_reg.empty <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_in_ready = state_reg.in_ready;
    assign o_out_valid = !state_reg.empty;
    assign o_out_data = state_reg.mem[state_reg.rd_ptr];

endmodule // tsr_fifo

`default_nettype wire

// ==== verilog/tsr_sdr_reg.sv ====
// single-data-rate tristate register with set/reset options
// assumes set/reset controls already passed through the cell control mux
`timescale 1ns/100ps
`default_nettype none

module tsr_sdr_reg (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // data
    input wire logic i_d,
    // set/reset options
    input wire logic i_init_set,
    input wire logic i_local_sync,
    input wire logic i_local_mux_out,
    input wire logic i_global_mux_out,
    // result
    output logic o_q
);
    logic async_clr;
    logic async_set;
    logic d_next;
    logic q_lo_reg;
    logic q_hi_reg;

    always_comb begin
        async_clr = i_local_mux_out && !i_local_sync && !i_init_set;
        async_set = i_local_mux_out && !i_local_sync && i_init_set;
        d_next = i_d;
        // sync set/reset
        if (i_sys_rst || i_global_mux_out || (i_local_mux_out && i_local_sync)) begin
            d_next = i_init_set;
        end
    end

    always_ff @(posedge i_core_clk or posedge async_clr) begin
        if (async_clr) begin
            q_lo_reg <= 1'b0;
        end else begin
            q_lo_reg <= d_next;
        end
    end

    always_ff @(posedge i_core_clk or posedge async_set) begin
        if (async_set) begin
            q_hi_reg <= 1'b1;
        end else begin
            q_hi_reg <= d_next;
        end
    end

    assign o_q = i_init_set ? q_hi_reg : q_lo_reg;

endmodule // tsr_sdr_reg

`default_nettype wire

// ==== verilog/tsr_tristate_path.sv ====
// tristate control register path of one programmable i/o cell group
// assumes all inputs synchronous to i_core_clk, the high-speed clock;
// low-speed words arrive through a valid/ready handshake
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module tsr_tristate_path #(
    parameter int WORD_W = 4,
    parameter int FIFO_DEPTH = 4,
    parameter int CELLS = 4
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // core-side tristate and cell data
    input wire logic i_tristate_in,
    input wire logic i_out_data,
    // source and gearing select
    input wire logic [1:0] i_src_sel,
    input wire logic [1:0] i_gear_sel,
    // set/reset configuration
    input wire logic i_local_set_reset,
    input wire logic i_local_sync,
    input wire logic i_init_set,
    input wire logic i_global_set_reset,
    input wire logic i_global_enable,
    // termination mode
    input wire logic i_mem_term_mode,
    // low-speed parallel words
    input wire logic i_word_valid,
    input wire logic [WORD_W-1:0] i_word,
    output logic o_word_ready,
    // ordinary outputs of cells left free
    input wire logic [CELLS-1:0] i_spare_data,
    output logic [CELLS-1:0] o_spare_out,
    output logic [CELLS-1:0] o_spare_free,
    // towards the i/o buffer
    output logic o_tristate_out,
    output logic o_term_on,
    output logic o_gear_busy
);
    import tsr_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic tristate_out;
        logic term_on;
        logic gear_bit;
        logic [TSR_SHIFT_REGS-1:0] shift;
        logic [1:0] cnt;
        logic gear_busy;
        logic [CELLS-1:0] spare_out;
        logic [CELLS-1:0] spare_free;
    } tsr_state_type;

    tsr_state_type state_reg;
    tsr_state_type state_next;

    logic local_set_reset_mux_out;
    logic global_set_reset_mux_out;
    logic sdr_q;
    logic fifo_valid;
    logic [WORD_W-1:0] fifo_data;
    logic fifo_in_ready;
    logic pop;
    logic [1:0] ratio_cnt;
    logic [CELLS-1:0] used_mask;
    logic src_bit;

    // ---------------------------------------------------------------
    // cell control mux
    // ---------------------------------------------------------------
    // local reset via control mux
    assign local_set_reset_mux_out = i_local_set_reset;
    assign global_set_reset_mux_out = i_global_set_reset && i_global_enable;

    // ---------------------------------------------------------------
    // single-data-rate register
    // ---------------------------------------------------------------
    tsr_sdr_reg u_sdr (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_d(i_tristate_in),
        .i_init_set(i_init_set),
        .i_local_sync(i_local_sync),
        .i_local_mux_out(local_set_reset_mux_out),
        .i_global_mux_out(global_set_reset_mux_out),
        .o_q(sdr_q)
    );

    // ---------------------------------------------------------------
    // word buffer from the slow side
    // ---------------------------------------------------------------
    // slow-side handover
    tsr_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_word_valid),
        .i_in_data(i_word),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(pop)
    );

    // ---------------------------------------------------------------
    // gearing decode
    // ---------------------------------------------------------------
    // cells per ratio
    always_comb begin
        if (i_gear_sel == TSR_GEAR_X4) begin
            ratio_cnt = TSR_CNT_X4;
            used_mask = CELLS'(TSR_USED_X4);
        end else if (i_gear_sel == TSR_GEAR_X2) begin
            ratio_cnt = TSR_CNT_X2;
            used_mask = CELLS'(TSR_USED_X2);
        end else begin
            ratio_cnt = TSR_CNT_X1;
            used_mask = CELLS'(TSR_USED_X1);
        end
    end

    assign pop = (state_reg.cnt == 2'h0) && fifo_valid;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (state_reg.cnt != 2'h0) begin
            state_next.gear_bit = state_reg.shift[0];
            state_next.shift = {1'b0, state_reg.shift[TSR_SHIFT_REGS-1:1]};
            state_next.cnt = state_reg.cnt - 2'h1;
        end else if (pop) begin
            state_next.gear_bit = fifo_data[0];
            state_next.shift = fifo_data[TSR_SHIFT_REGS:1];
            state_next.cnt = ratio_cnt;
        end
        state_next.gear_busy = (state_next.cnt != 2'h0);
        if (i_src_sel == TSR_SRC_BYPASS) begin
            src_bit = i_tristate_in;
        end else if (i_src_sel == TSR_SRC_SDR) begin
            src_bit = sdr_q;
        end else if (i_src_sel == TSR_SRC_DDR) begin
            src_bit = state_next.gear_bit;
        end else begin
            src_bit = i_out_data;
        end
        state_next.tristate_out = src_bit;
        state_next.term_on = i_mem_term_mode && src_bit;
        state_next.spare_free = ~used_mask;
        state_next.spare_out = i_spare_data & ~used_mask;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_reg <= '0;
            state_reg.tristate_out <= TSR_RST_TRISTATE;
            state_reg.term_on <= TSR_RST_TERM;
            state_reg.gear_bit <= TSR_RST_BIT;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_tristate_out = state_reg.tristate_out;
    assign o_term_on = state_reg.term_on;
    assign o_gear_busy = state_reg.gear_busy;
    assign o_word_ready = fifo_in_ready;
    assign o_spare_out = state_reg.spare_out;
    assign o_spare_free = state_reg.spare_free;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    AST_SDR_CAPTURE: assert property (
        (i_src_sel == TSR_SRC_SDR && !local_set_reset_mux_out && !global_set_reset_mux_out)
        ##1 (i_src_sel == TSR_SRC_SDR && !local_set_reset_mux_out)
        |-> ##1 (o_tristate_out == $past(i_tristate_in, 2))
    ) else $error("sdr path does not follow input two edges later");

    AST_SHIFT_DEPTH: assert property (
        (pop && i_gear_sel == TSR_GEAR_X4)
        |=> (state_reg.cnt == 2'h3) ##1 (state_reg.cnt == 2'h2) ##1 (state_reg.cnt == 2'h1)
    ) else $error("x4 word not held across the three shift registers");

    AST_SRC_BYPASS: assert property (
        (i_src_sel == TSR_SRC_BYPASS) |=> (o_tristate_out == $past(i_tristate_in))
    ) else $error("bypass source not passed through");

    AST_SRC_OPEN_DRAIN: assert property (
        (i_src_sel == TSR_SRC_OPEN_DRAIN) |=> (o_tristate_out == $past(i_out_data))
    ) else $error("open-drain source not passed through");

    AST_LOCAL_ASYNC: assert property (
        (local_set_reset_mux_out && !i_local_sync) |-> (sdr_q == i_init_set)
    ) else $error("async local set/reset not applied");

    AST_LOCAL_SYNC: assert property (
        (local_set_reset_mux_out && i_local_sync && $stable(i_init_set))
        |=> (sdr_q == $past(i_init_set))
    ) else $error("sync local set/reset not applied");

    AST_GLOBAL_GATED: assert property (
        (i_global_set_reset && !i_global_enable && !local_set_reset_mux_out)
        |=> (sdr_q == $past(i_tristate_in))
    ) else $error("disabled global set/reset still acted");

    AST_GEAR_ORDER: assert property (
        (pop && i_gear_sel == TSR_GEAR_X2)
        |=> (state_reg.gear_bit == $past(fifo_data[0]))
        ##1 (state_reg.gear_bit == $past(fifo_data[1], 2))
    ) else $error("x2 word not serialised lowest bit first");

    AST_TERM_OFF: assert property (
        (i_mem_term_mode && i_src_sel == TSR_SRC_BYPASS && !i_tristate_in) |=> !o_term_on
    ) else $error("termination on while driving");

    AST_TERM_ON: assert property (
        (!$past(i_sys_rst) && $past(i_mem_term_mode) && o_tristate_out) |-> o_term_on
    ) else $error("termination off while released in memory mode");

    AST_X1_NO_HOLD: assert property (
        (pop && i_gear_sel == TSR_GEAR_X1) |=> (state_reg.cnt == 2'h0)
    ) else $error("x1 word held more than one edge");

    AST_SPARE_FREE: assert property (
        (i_gear_sel == TSR_GEAR_X2) |=> (o_spare_free == ~CELLS'(TSR_USED_X2))
    ) else $error("free cells wrong under x2 gearing");

    AST_NO_EARLY_LOAD: assert property (
        (state_reg.cnt != 2'h0 && fifo_valid) |=> (fifo_valid && $stable(fifo_data))
    ) else $error("word loaded before previous one drained");

    AST_WORD_STORED: assert property (
        (i_word_valid && o_word_ready)
        |=> fifo_valid
    ) else $error("offered word not stored");

    AST_READY_AFTER_RESET: assert property (
        $fell(i_sys_rst)
        |=> o_word_ready
    ) else $error("word ready not raised after reset");

    AST_X4_ORDER: assert property (
        (pop && i_gear_sel == TSR_GEAR_X4)
        |=> (state_reg.gear_bit == $past(fifo_data[0]))
        ##1 (state_reg.gear_bit == $past(fifo_data[1], 2))
        ##1 (state_reg.gear_bit == $past(fifo_data[2], 3))
        ##1 (state_reg.gear_bit == $past(fifo_data[3], 4))
    ) else $error("x4 word not serialised lowest bit first");

    AST_X4_BUSY: assert property (
        (pop && i_gear_sel == TSR_GEAR_X4)
        |=> o_gear_busy [*3] ##1 !o_gear_busy
    ) else $error("x4 word busy span wrong");

    AST_X2_BUSY: assert property (
        (pop && i_gear_sel == TSR_GEAR_X2)
        |=> o_gear_busy ##1 !o_gear_busy
    ) else $error("x2 word busy span wrong");

    AST_X1_BUSY: assert property (
        (pop && i_gear_sel == TSR_GEAR_X1)
        |=> !o_gear_busy
    ) else $error("x1 word marked busy");

    AST_SRC_DDR: assert property (
        (i_src_sel == TSR_SRC_DDR)
        |=> (o_tristate_out == state_reg.gear_bit)
    ) else $error("gearbox source not passed through");

    AST_TERM_MODE_OFF: assert property (
        !i_mem_term_mode
        |=> !o_term_on
    ) else $error("termination on outside memory mode");

    AST_ODRAIN_TERM: assert property (
        (i_mem_term_mode && i_src_sel == TSR_SRC_OPEN_DRAIN && i_out_data)
        |=> o_term_on
    ) else $error("termination off while open-drain released");

    AST_SPARE_X4: assert property (
        (i_gear_sel == TSR_GEAR_X4)
        |=> (o_spare_free == '0 && o_spare_out == '0)
    ) else $error("free cells reported under x4 gearing");

    AST_SPARE_X1: assert property (
        (i_gear_sel == TSR_GEAR_X1)
        |=> (o_spare_free == ~CELLS'(TSR_USED_X1))
    ) else $error("free cells wrong under x1 gearing");

    AST_SPARE_DATA: assert property (
        (i_gear_sel == TSR_GEAR_X2)
        |=> (o_spare_out[CELLS-1:2] == $past(i_spare_data[CELLS-1:2]))
    ) else $error("free cell data not passed under x2 gearing");

    AST_SDR_INIT: assert property (
        ($fell(i_sys_rst) && !local_set_reset_mux_out)
        |-> (sdr_q == $past(i_init_set))
    ) else $error("sdr register not loaded with init action at reset");

    AST_GLOBAL_SET: assert property (
        (global_set_reset_mux_out && !local_set_reset_mux_out)
        |=> (sdr_q == $past(i_init_set))
    ) else $error("enabled global set/reset not applied");

    COV_X4_WORD: cover property (pop && i_gear_sel == TSR_GEAR_X4 && i_src_sel == TSR_SRC_DDR);
    COV_FIFO_FULL: cover property (!o_word_ready && i_word_valid);
    COV_TERM_SWITCH: cover property (i_mem_term_mode && o_term_on ##1 !o_term_on);
    COV_ASYNC_SET: cover property (local_set_reset_mux_out && !i_local_sync && i_init_set);
    COV_X2_WORD: cover property (pop && i_gear_sel == TSR_GEAR_X2);

endmodule // tsr_tristate_path

`default_nettype wire

// ==== bench/tsr_word_src.sv ====
// fabric-side source of low-speed parallel tristate words
// assumes registered o_word_ready, inputs driven at the falling clock edge
`timescale 1ns/100ps
`default_nettype none

module tsr_word_src (
    // clock
    input wire logic i_core_clk,
    // handshake
    input wire logic i_word_ready,
    output logic o_word_valid,
    output logic [tsr_pkg::TSR_WORD_W-1:0] o_word
);
    import tsr_pkg::*;

    int taken = 0;

    initial begin
        o_word_valid = 1'b0;
        o_word = 4'h0;
    end

    // ---------------------------------------------------------------
    // word hand-over
    // ---------------------------------------------------------------
    // hold valid and word until ready stands at the taking edge
    task automatic push(input logic [TSR_WORD_W-1:0] w);
        @(negedge i_core_clk);
        o_word_valid = 1'b1;
        o_word = w;
        while (i_word_ready !== 1'b1) begin
            @(negedge i_core_clk);
        end
        @(posedge i_core_clk);
        taken++;
        @(negedge i_core_clk);
        o_word_valid = 1'b0;
        o_word = ~w;
    endtask
endmodule // tsr_word_src

`default_nettype wire

// ==== bench/tb.sv ====
// self-checking testbench of the tristate register path
// assumes the word source model and the design package are compiled first
`timescale 1ns/100ps
`default_nettype none

module tb;
    import tsr_pkg::*;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic clk, rst, tri_in, out_data, local_sr, local_sync, init_set;
    logic global_sr, global_en, term_mode;
    logic [1:0] src_sel, gear_sel;
    logic word_valid, word_ready, tri_out, term_on, gear_busy, seen_full;
    logic [3:0] word, spare_data, spare_out, spare_free;
    int errors = 0;
    int checks = 0;

    // ---------------------------------------------------------------
    // design and word source
    // ---------------------------------------------------------------
    tsr_tristate_path #(.WORD_W(TSR_WORD_W), .FIFO_DEPTH(TSR_FIFO_DEPTH),
        .CELLS(TSR_CELLS)) i_dut (
        .i_core_clk(clk), .i_sys_rst(rst), .i_tristate_in(tri_in), .i_out_data(out_data),
        .i_src_sel(src_sel), .i_gear_sel(gear_sel), .i_local_set_reset(local_sr),
        .i_local_sync(local_sync), .i_init_set(init_set), .i_global_set_reset(global_sr),
        .i_global_enable(global_en), .i_mem_term_mode(term_mode), .i_word_valid(word_valid),
        .i_word(word), .o_word_ready(word_ready), .i_spare_data(spare_data),
        .o_spare_out(spare_out), .o_spare_free(spare_free), .o_tristate_out(tri_out),
        .o_term_on(term_on), .o_gear_busy(gear_busy));

    tsr_word_src i_src (
        .i_core_clk(clk),
        .i_word_ready(word_ready),
        .o_word_valid(word_valid),
        .o_word(word)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(negedge clk) begin
        if (rst === 1'b0 && word_ready === 1'b0) begin
            seen_full = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // compare and close
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_reset();
        chk("reset tristate", tri_out, TSR_RST_TRISTATE);
        chk("reset term", term_on, TSR_RST_TERM);
        chk("reset busy", gear_busy, 0);
        chk("reset spare", spare_out, 0);
        chk("reset ready", word_ready, 0);
        rst = 1'b0;
        @(negedge clk);
        chk("ready after reset", word_ready, 1);
        $display("reset test done");
    endtask

    task automatic test_bypass();
        src_sel = TSR_SRC_BYPASS;
        for (int i = 0; i < 4; i++) begin
            tri_in = i[0];
            term_mode = i[1];
            @(negedge clk);
            chk("bypass", tri_out, i[0]);
            chk("termination", term_on, i[0] & i[1]);
        end
        src_sel = TSR_SRC_OPEN_DRAIN;
        for (int i = 0; i < 2; i++) begin
            out_data = i[0];
            tri_in = ~i[0];
            @(negedge clk);
            chk("open drain", tri_out, i[0]);
            chk("open drain term", term_on, i[0]);
        end
        term_mode = 1'b0;
        $display("bypass test done");
    endtask

    task automatic test_sdr();
        src_sel = TSR_SRC_SDR;
        tri_in = 1'b1;
        repeat (3) @(negedge clk);
        tri_in = 1'b0;
        @(negedge clk);
        chk("sdr lag", tri_out, 1);
        @(negedge clk);
        chk("sdr capture", tri_out, 0);
        local_sr = 1'b1;
        @(negedge clk);
        chk("sync set lag", tri_out, 0);
        @(negedge clk);
        chk("sync set", tri_out, 1);
        local_sr = 1'b0;
        repeat (2) @(negedge clk);
        chk("sdr recapture", tri_out, 0);
        local_sync = 1'b0;
        local_sr = 1'b1;
        @(negedge clk);
        chk("async set", tri_out, 1);
        local_sr = 1'b0;
        local_sync = 1'b1;
        global_sr = 1'b1;
        repeat (3) @(negedge clk);
        chk("global gated", tri_out, 0);
        global_en = 1'b1;
        repeat (2) @(negedge clk);
        chk("global set", tri_out, 1);
        global_sr = 1'b0;
        init_set = 1'b0;
        tri_in = 1'b1;
        local_sr = 1'b1;
        repeat (2) @(negedge clk);
        chk("sync reset init", tri_out, 0);
        local_sr = 1'b0;
        init_set = 1'b1;
        $display("sdr test done");
    endtask

    task automatic send_bits(input logic [1:0] gear, input logic [3:0] w, input int n);
        int k;
        k = 0;
        gear_sel = gear;
        i_src.push(w);
        while (gear_busy !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk("gear start", gear_busy, 1);
        for (int i = 0; i < n; i++) begin
            chk("gear bit", tri_out, w[i]);
            if (i < n - 1) begin
                @(negedge clk);
            end
        end
        chk("gear done", gear_busy, 0);
        repeat (3) @(negedge clk);
        chk("gear hold", tri_out, w[n-1]);
    endtask

    task automatic test_gear();
        src_sel = TSR_SRC_DDR;
        gear_sel = TSR_GEAR_X1;
        i_src.push(4'h1);
        repeat (4) @(negedge clk);
        chk("x1 bit", tri_out, 1);
        i_src.push(4'hE);
        repeat (4) @(negedge clk);
        chk("x1 upper ignored", tri_out, 0);
        send_bits(TSR_GEAR_X2, 4'h2, 2);
        send_bits(TSR_GEAR_X2, 4'hD, 2);
        send_bits(TSR_GEAR_X4, 4'hC, 4);
        send_bits(TSR_GEAR_X4, 4'hD, 4);
        $display("gear test done");
    endtask

    task automatic test_spare();
        logic [3:0] free [4];
        free = '{4'hE, 4'hC, 4'h0, 4'hE};
        spare_data = 4'hB;
        for (int g = 0; g < 4; g++) begin
            gear_sel = g[1:0];
            repeat (2) @(negedge clk);
            chk("spare free", spare_free, free[g]);
            chk("spare out", spare_out, spare_data & free[g]);
        end
        $display("spare test done");
    endtask

    task automatic test_fill();
        src_sel = TSR_SRC_DDR;
        gear_sel = TSR_GEAR_X4;
        i_src.taken = 0;
        seen_full = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            i_src.push(i[3:0]);
        end
        repeat (40) @(negedge clk);
        chk("fifo refused", seen_full, 1);
        chk("words taken", i_src.taken[3:0], 4'h8);
        chk("drained ready", word_ready, 1);
        chk("drained busy", gear_busy, 0);
        chk("last bit held", tri_out, 1);
        $display("fill test done");
    endtask

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        rst = 1'b1;
        tri_in = 1'b1;
        out_data = 1'b0;
        src_sel = TSR_SRC_BYPASS;
        gear_sel = TSR_GEAR_X1;
        local_sr = 1'b0;
        local_sync = 1'b1;
        init_set = 1'b1;
        global_sr = 1'b0;
        global_en = 1'b0;
        term_mode = 1'b0;
        spare_data = 4'hB;
        seen_full = 1'b0;
        repeat (20) @(negedge clk);
        test_reset();
        test_bypass();
        test_sdr();
        test_gear();
        test_spare();
        test_fill();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
